// ---- src/gpcfg_top.sv ----
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// pin configuration, debug status and fixed-pin overrides for three 8-pin ports
module gpcfg_top #(
    parameter int NPORTS = 3,
    parameter int NPINS = 24
) (
    input wire logic clk_in,                    // 20 MHz system clock
    input wire logic srst_in,                   // synchronous reset, high
    input wire logic por_in,                    // power-on reset indication, high
    input wire logic external_reset_in_n,       // pin reset, low
    input wire logic boot_select_in_n,          // boot-select level, low
    input wire logic [31:0] addr_in,            // register byte address
    input wire logic [31:0] wdata_in,           // write data
    input wire logic wr_in,                     // write strobe
    input wire logic rd_in,                     // read strobe
    output logic [31:0] rdata_out,              // read data, cycle after rd_in
    input wire logic jtag_on_in,                // jtag debug mode active
    input wire logic sw_on_in,                  // serial-wire debug mode active
    input wire logic sw_drive_in,               // debugger wants swdio driven
    input wire logic sw_data_in,                // swdio data from debug port
    input wire logic forced_debug_in,           // debug forced by hardware
    input wire logic jtag_data_out_in,          // jtag test data output
    input wire logic reg_enable_in,             // regulator enable signal
    input wire logic [3:0] timer_ch_in,         // second timer channel outputs
    input wire logic [NPINS-1:0] alt_data_in,   // other peripheral outputs
    input wire logic [NPINS-1:0] pad_in,        // pad levels
    output logic [NPINS-1:0] pad_out,           // pad output value
    output logic [NPINS-1:0] pad_oe_n_out,      // pad output enable, low drives
    output logic [NPINS-1:0] pull_up_out,       // pull-up enable
    output logic [NPINS-1:0] pull_down_out,     // pull-down enable
    output logic [NPINS-1:0] level_out,         // digital input path to peripherals
    output logic debugger_disable_out,          // debugger disabled by software
    output logic timer_remap_out                // second timer remap selected
);
    logic [15:0] mode_lo_q [NPORTS];
    logic [15:0] mode_lo_d [NPORTS];
    logic [15:0] mode_hi_q [NPORTS];
    logic [15:0] mode_hi_d [NPORTS];
    logic [7:0] out_q [NPORTS];
    logic [7:0] out_d [NPORTS];
    logic [gpcfg_pkg::DBG_CTRL_W-1:0] dbg_ctrl_q, dbg_ctrl_d;
    logic boot_flag_q, boot_flag_d;
    logic [31:0] rdata_q, rdata_d;
    logic [4*NPINS-1:0] sw_modes, eff_modes;
    logic [NPINS-1:0] out_bits, alt_bits, force_data, force_pu, data_mux;
    logic [NPINS-1:0] dl, dh, pu, pd, lvl;
    logic [NPINS-1:0] pad_q, oe_n_q, pu_q, pd_q, lvl_q;

    // register file
    always_comb begin
        logic [31:0] base;
        logic [31:0] ofs;
        base = '0;
        ofs = '0;
        dbg_ctrl_d = dbg_ctrl_q;
        for (int p = 0; p < NPORTS; p++) begin
            mode_lo_d[p] = mode_lo_q[p];
            mode_hi_d[p] = mode_hi_q[p];
            out_d[p] = out_q[p];
        end
        rdata_d = '0;
        if (addr_in == gpcfg_pkg::DEBUG_CTRL_ADDR) begin
            if (wr_in) begin
                dbg_ctrl_d = wdata_in[gpcfg_pkg::DBG_CTRL_W-1:0];
            end
            rdata_d[gpcfg_pkg::DBG_CTRL_W-1:0] = dbg_ctrl_q;
        end else if (addr_in == gpcfg_pkg::DEBUG_STATE_ADDR) begin
            // status has no write path at all
            rdata_d[gpcfg_pkg::ST_SW_BIT] = sw_on_in;
            rdata_d[gpcfg_pkg::ST_FORCED_BIT] = forced_debug_in;
            rdata_d[gpcfg_pkg::ST_BOOT_BIT] = boot_flag_q;
        end
        for (int p = 0; p < NPORTS; p++) begin
            base = gpcfg_pkg::PA_MODE_LOW_ADDR + 32'(p) * 32'h0000_0400;
            ofs = addr_in - base;
            if (ofs == 32'h0000_0000) begin
                if (wr_in) begin
                    mode_lo_d[p] = wdata_in[15:0];
                end
                rdata_d = {16'h0000, mode_lo_q[p]};
            end else if (ofs == gpcfg_pkg::MODE_HIGH_OFS) begin
                if (wr_in) begin
                    mode_hi_d[p] = wdata_in[15:0];
                end
                rdata_d = {16'h0000, mode_hi_q[p]};
            end else if (ofs == gpcfg_pkg::IN_LEVEL_OFS) begin
                rdata_d = {24'h00_0000, lvl_q[8*p +: 8]};
            end else if (ofs == gpcfg_pkg::OUT_DATA_OFS) begin
                if (wr_in) begin
                    out_d[p] = wdata_in[7:0];
                end
                rdata_d = {24'h00_0000, out_q[p]};
            end
        end
        if (!rd_in) begin
            rdata_d = '0;
        end
    end

    // boot-select caught on every clocked cycle of a power-on or pin reset, so the last cycle's level is kept
    always_comb begin
        boot_flag_d = boot_flag_q;
        if (srst_in && (por_in || !external_reset_in_n)) begin
            boot_flag_d = ~boot_select_in_n;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int p = 0; p < NPORTS; p++) begin
                mode_lo_q[p] <= gpcfg_pkg::MODE_RESET;
                mode_hi_q[p] <= gpcfg_pkg::MODE_RESET;
                out_q[p] <= 8'h00;
            end
            dbg_ctrl_q <= gpcfg_pkg::DBG_CTRL_RESET;
            rdata_q <= '0;
        end else begin
            for (int p = 0; p < NPORTS; p++) begin
                mode_lo_q[p] <= mode_lo_d[p];
                mode_hi_q[p] <= mode_hi_d[p];
                out_q[p] <= out_d[p];
            end
            dbg_ctrl_q <= dbg_ctrl_d;
            rdata_q <= rdata_d;
        end
        // flag survives other resets, so it is outside the reset branch
        boot_flag_q <= boot_flag_d;
    end

    // flatten per-pin state, choose peripheral sources
    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            sw_modes[32*p +: 16] = mode_lo_q[p];
            sw_modes[32*p+16 +: 16] = mode_hi_q[p];
            out_bits[8*p +: 8] = out_q[p];
        end
        alt_bits = alt_data_in;
        for (int c = 0; c < 4; c++) begin
            if (dbg_ctrl_q[gpcfg_pkg::DBG_TIMER_REMAP_BIT]) begin
                alt_bits[gpcfg_pkg::TIMER_REMAP_BASE + c] = timer_ch_in[c];
            end else begin
                // default channels are not in pin order on port A
                alt_bits[gpcfg_pkg::TIMER_DEFAULT_BASE
                    + int'(gpcfg_pkg::TIMER_DEFAULT_ORDER[2*c +: 2])] = timer_ch_in[c];
            end
        end
        data_mux = alt_bits;
        if (force_data[gpcfg_pkg::REG_EN_PIN]) data_mux[gpcfg_pkg::REG_EN_PIN] = reg_enable_in;
        if (force_data[gpcfg_pkg::JTAG_TDO_PIN]) data_mux[gpcfg_pkg::JTAG_TDO_PIN] = jtag_data_out_in;
        if (force_data[gpcfg_pkg::SW_DATA_PIN]) data_mux[gpcfg_pkg::SW_DATA_PIN] = sw_data_in;
    end

    gpcfg_override #(.NPINS(NPINS)) u_ovr (
        .mode_in(sw_modes),
        .rst_active_in(srst_in),
        .jtag_on_in(jtag_on_in & ~dbg_ctrl_q[gpcfg_pkg::DBG_DISABLE_BIT]),
        .sw_on_in(sw_on_in & ~dbg_ctrl_q[gpcfg_pkg::DBG_DISABLE_BIT]),
        .sw_drive_in(sw_drive_in),
        .mode_out(eff_modes),
        .force_data_out(force_data),
        .force_pull_up_out(force_pu)
    );

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            gpcfg_pin_cell u_cell (
                .mode_in(eff_modes[4*g +: 4]),
                .out_data_in(out_bits[g] | force_pu[g]),
                .alt_data_in(data_mux[g]),
                .pad_in(pad_in[g]),
                .drive_low_out(dl[g]),
                .drive_high_out(dh[g]),
                .pull_up_out(pu[g]),
                .pull_down_out(pd[g]),
                .level_out(lvl[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        pad_q <= dh;
        oe_n_q <= ~(dl | dh);
        pu_q <= pu;
        pd_q <= pd;
        lvl_q <= lvl;
    end

    assign rdata_out = rdata_q;
    assign pad_out = pad_q;
    assign pad_oe_n_out = oe_n_q;
    assign pull_up_out = pu_q;
    assign pull_down_out = pd_q;
    assign level_out = lvl_q;
    assign debugger_disable_out = dbg_ctrl_q[gpcfg_pkg::DBG_DISABLE_BIT];
    assign timer_remap_out = dbg_ctrl_q[gpcfg_pkg::DBG_TIMER_REMAP_BIT];

    chk_reset_mode_value: assert property (@(posedge clk_in) disable iff (srst_in)
        $past(srst_in) |-> mode_lo_q[0] == 16'h4444)
        else $error("mode register not at reset value");
    chk_upper_bits_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        rdata_out[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_boot_pin_pull: assert property (@(posedge clk_in) srst_in |=> pull_up_out[gpcfg_pkg::BOOT_SEL_PIN])
        else $error("boot pin not pulled up in reset");
    chk_regen_no_source: assert property (@(posedge clk_in) disable iff (srst_in)
        !srst_in ##1 !srst_in |-> !pad_out[gpcfg_pkg::REG_EN_PIN])
        else $error("regulator pin sourcing current");
    chk_analog_level: assert property (@(posedge clk_in) disable iff (srst_in)
        (eff_modes[3:0] == 4'h0) |=> level_out[0])
        else $error("analog pin input not high");
    chk_tdo_drives: assert property (@(posedge clk_in) disable iff (srst_in)
        (jtag_on_in && !debugger_disable_out) |=> !pad_oe_n_out[gpcfg_pkg::JTAG_TDO_PIN])
        else $error("jtag data out not driven");
    chk_tdi_pull: assert property (@(posedge clk_in) disable iff (srst_in)
        (jtag_on_in && !debugger_disable_out) |=> pull_up_out[gpcfg_pkg::JTAG_TDI_PIN])
        else $error("jtag data in not pulled up");
    chk_status_read: assert property (@(posedge clk_in) disable iff (srst_in)
        rd_in && addr_in == gpcfg_pkg::DEBUG_STATE_ADDR |=> rdata_out[gpcfg_pkg::ST_SW_BIT] == $past(sw_on_in))
        else $error("status read mismatch");
endmodule
`default_nettype wire

// ---- inc/gpcfg_pkg.sv ----
// Summary of operation
// - debug control register holds a debugger-disable bit, a timer-remap bit and spare control bits.
// - read-only debug status reports forced-debug and serial-wire-active; writes ignored.
// - debug status holds boot-select level caught at last power-on or pin reset.
// - low mode register: pin3 [15:12], pin2 [11:8], pin1 [7:4], pin0 [3:0].
// - mode 0 is analog; that pin's input bit reads one.
// - mode 1 push-pull, mode 5 open-drain, level from output data bit.
// - mode 4 floating input; mode 8 pulled input, direction from output data bit.
// - mode 9 push-pull, mode 13 open-drain alternate output driven by peripheral.
// - all three low mode registers reset to all floating inputs.
// - during reset the boot-select pin is an input with pull-up.
// - after reset the regulator-enable pin is open-drain driven by that signal.
// - in jtag mode, jtag data-out pin becomes a push-pull output.
// - in serial-wire mode the data pin direction follows the debugger.
// - second timer channels on port A pins 0-3, or port B pins 1-4 remapped.
// - high mode registers cover pins 7-4 with same coding, reset all floating.
// - analog mode disables drivers and pulls and ties digital input high.
package gpcfg_pkg;
    localparam logic [31:0] PA_MODE_LOW_ADDR = 32'h4000_b000;
    localparam logic [31:0] PB_MODE_LOW_ADDR = 32'h4000_b400;
    localparam logic [31:0] PC_MODE_LOW_ADDR = 32'h4000_b800;
    localparam logic [31:0] MODE_HIGH_OFS = 32'h0000_0004;
    localparam logic [31:0] OUT_DATA_OFS = 32'h0000_000c;
    localparam logic [31:0] IN_LEVEL_OFS = 32'h0000_0008;
    localparam logic [31:0] DEBUG_CTRL_ADDR = 32'h4000_bc00;
    localparam logic [31:0] DEBUG_STATE_ADDR = 32'h4000_bc04;
    localparam logic [15:0] MODE_RESET = 16'h4444;
    localparam int FIELD_W = 4;
    localparam logic [3:0] M_ANALOG = 4'h0;
    localparam logic [3:0] M_OUT_PP = 4'h1;
    localparam logic [3:0] M_IN_FLOAT = 4'h4;
    localparam logic [3:0] M_OUT_OD = 4'h5;
    localparam logic [3:0] M_IN_PULL = 4'h8;
    localparam logic [3:0] M_ALT_PP = 4'h9;
    localparam logic [3:0] M_ALT_OD = 4'hd;
    // debug control fields
    localparam int DBG_DISABLE_BIT = 0;
    localparam int DBG_TIMER_REMAP_BIT = 1;
    localparam int DBG_CTRL_W = 4;
    localparam logic [3:0] DBG_CTRL_RESET = 4'h0;
    // debug state fields
    localparam int ST_SW_BIT = 0;
    localparam int ST_FORCED_BIT = 1;
    localparam int ST_BOOT_BIT = 3;
    // fixed pin indices, flat index = port*8 + pin
    localparam int BOOT_SEL_PIN = 5;
    localparam int REG_EN_PIN = 7;
    localparam int JTAG_RST_PIN = 16;
    localparam int JTAG_TDO_PIN = 18;
    localparam int JTAG_TDI_PIN = 19;
    localparam int SW_DATA_PIN = 20;
    localparam int TIMER_DEFAULT_BASE = 0;
    // port A pin offset of each timer channel, two bits per channel: 1->0, 2->3, 3->1, 4->2
    localparam logic [7:0] TIMER_DEFAULT_ORDER = 8'h9c;
    localparam int TIMER_REMAP_BASE = 9;
endpackage

// ---- src/gpcfg_pin_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
// one pin: decodes its 4-bit mode into pad controls
module gpcfg_pin_cell (
    input wire logic [3:0] mode_in,   // effective mode code
    input wire logic out_data_in,     // output data bit
    input wire logic alt_data_in,     // peripheral data
    input wire logic pad_in,          // level at the pad
    output logic drive_low_out,       // n-mos sink on
    output logic drive_high_out,      // p-mos source on
    output logic pull_up_out,         // pull-up on
    output logic pull_down_out,       // pull-down on
    output logic level_out            // digital input path
);
    logic data;
    always_comb begin
        drive_low_out = 1'b0;
        drive_high_out = 1'b0;
        pull_up_out = 1'b0;
        pull_down_out = 1'b0;
        level_out = pad_in;
        data = out_data_in;
        case (mode_in)
            gpcfg_pkg::M_ANALOG: begin
                level_out = 1'b1;
            end
            gpcfg_pkg::M_OUT_PP, gpcfg_pkg::M_ALT_PP: begin
                data = (mode_in == gpcfg_pkg::M_ALT_PP) ? alt_data_in : out_data_in;
                drive_low_out = ~data;
                drive_high_out = data;
            end
            gpcfg_pkg::M_OUT_OD, gpcfg_pkg::M_ALT_OD: begin
                data = (mode_in == gpcfg_pkg::M_ALT_OD) ? alt_data_in : out_data_in;
                drive_low_out = ~data;
            end
            gpcfg_pkg::M_IN_PULL: begin
                pull_up_out = out_data_in;
                pull_down_out = ~out_data_in;
            end
            // unlisted codes behave as a floating input
            default: begin
                level_out = pad_in;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- src/gpcfg_override.sv ----
`timescale 1ns/1ps
`default_nettype none
// imposes fixed-pin overrides on the software mode fields
module gpcfg_override #(
    parameter int NPINS = 24
) (
    input wire logic [4*NPINS-1:0] mode_in,     // software modes
    input wire logic rst_active_in,              // reset in progress
    input wire logic jtag_on_in,                 // jtag debug active
    input wire logic sw_on_in,                   // serial-wire debug active
    input wire logic sw_drive_in,                // debugger drives swdio
    output logic [4*NPINS-1:0] mode_out,         // effective modes
    output logic [NPINS-1:0] force_data_out,     // forced data select
    output logic [NPINS-1:0] force_pull_up_out   // forced pull-up
);
    always_comb begin
        mode_out = mode_in;
        force_data_out = '0;
        force_pull_up_out = '0;
        if (rst_active_in) begin
            mode_out[4*gpcfg_pkg::BOOT_SEL_PIN +: 4] = gpcfg_pkg::M_IN_PULL;
            force_pull_up_out[gpcfg_pkg::BOOT_SEL_PIN] = 1'b1;
        end else begin
            mode_out[4*gpcfg_pkg::REG_EN_PIN +: 4] = gpcfg_pkg::M_ALT_OD;
        end
        if (jtag_on_in) begin
            mode_out[4*gpcfg_pkg::JTAG_RST_PIN +: 4] = gpcfg_pkg::M_IN_PULL;
            mode_out[4*gpcfg_pkg::JTAG_TDI_PIN +: 4] = gpcfg_pkg::M_IN_PULL;
            force_pull_up_out[gpcfg_pkg::JTAG_RST_PIN] = 1'b1;
            force_pull_up_out[gpcfg_pkg::JTAG_TDI_PIN] = 1'b1;
            mode_out[4*gpcfg_pkg::JTAG_TDO_PIN +: 4] = gpcfg_pkg::M_ALT_PP;
        end
        if (sw_on_in) begin
            mode_out[4*gpcfg_pkg::SW_DATA_PIN +: 4] = sw_drive_in ? gpcfg_pkg::M_ALT_PP
                                                                 : gpcfg_pkg::M_IN_FLOAT;
            force_data_out[gpcfg_pkg::SW_DATA_PIN] = 1'b1;
        end
        if (!rst_active_in) begin
            force_data_out[gpcfg_pkg::REG_EN_PIN] = 1'b1;
        end
        if (jtag_on_in) begin
            force_data_out[gpcfg_pkg::JTAG_TDO_PIN] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/gpcfg_pad_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// board side of the pads: chip drivers, outside drivers and the chip's own pulls
module gpcfg_pad_model (
    input wire logic clk_in,              // system clock
    input wire logic [23:0] pad_out_in,   // chip pad value
    input wire logic [23:0] pad_oe_n_in,  // chip drive enable, low drives
    input wire logic [23:0] pull_up_in,   // chip pull-up
    input wire logic [23:0] pull_down_in, // chip pull-down
    input wire logic [23:0] ext_en_in,    // outside party drives the pad
    input wire logic [23:0] ext_level_in, // outside drive level
    output logic [23:0] pad_level_out     // resolved pad level
);
    logic [23:0] float_q = 24'h00_0000;
    // an undriven, unpulled pad wanders every cycle, so no check may lean on it
    always_ff @(posedge clk_in) begin
        float_q <= ~pad_level_out;
    end
    assign pad_level_out = (~pad_oe_n_in & pad_out_in)
        | (pad_oe_n_in & ext_en_in & ext_level_in)
        | (pad_oe_n_in & ~ext_en_in & (pull_up_in | (~pull_down_in & float_q)));
endmodule
`default_nettype wire

// ---- testbench/gpio_pin_config_debug_override_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_config_debug_override_test;
    logic clk_in = 1'h0, srst_in = 1'h1, por_in = 1'h1, external_reset_in_n = 1'h1, boot_select_in_n = 1'h0;
    logic [31:0] addr_in = 32'h0000_0000, wdata_in = 32'h0000_0000, rdata_out;
    logic wr_in = 1'h0, rd_in = 1'h0, jtag_on_in = 1'h0, sw_on_in = 1'h0, sw_drive_in = 1'h0, sw_data_in = 1'h0;
    logic forced_debug_in = 1'h0, jtag_data_out_in = 1'h0, reg_enable_in = 1'h0;
    logic debugger_disable_out, timer_remap_out;
    logic [3:0] timer_ch_in = 4'h0;
    logic [23:0] alt_data_in = 24'h00_0000, ext_en = 24'h00_0000, ext_level = 24'h00_0000;
    logic [23:0] pad_in, pad_out, pad_oe_n_out, pull_up_out, pull_down_out, level_out;
    int fails = 0, comparisons = 0;
    // timer channel carried by port A pins 0 to 3 when not remapped
    int pa_ch [4] = '{0, 2, 3, 1};
    // a code outside the documented set, expected to act as a floating input
    localparam logic [3:0] UNLISTED = 4'h2;

    always #25 clk_in = ~clk_in;

    gpcfg_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .por_in(por_in),
        .external_reset_in_n(external_reset_in_n), .boot_select_in_n(boot_select_in_n),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .jtag_on_in(jtag_on_in), .sw_on_in(sw_on_in), .sw_drive_in(sw_drive_in), .sw_data_in(sw_data_in),
        .forced_debug_in(forced_debug_in), .jtag_data_out_in(jtag_data_out_in), .reg_enable_in(reg_enable_in),
        .timer_ch_in(timer_ch_in), .alt_data_in(alt_data_in), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n_out(pad_oe_n_out), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
        .level_out(level_out), .debugger_disable_out(debugger_disable_out), .timer_remap_out(timer_remap_out));

    gpcfg_pad_model pm_u (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n_out),
        .pull_up_in(pull_up_out), .pull_down_in(pull_down_out), .ext_en_in(ext_en),
        .ext_level_in(ext_level), .pad_level_out(pad_in));

    function automatic logic [31:0] base(input int p);
        return gpcfg_pkg::PA_MODE_LOW_ADDR + 32'(p) * 32'h0000_0400;
    endfunction
    // {mask, expected} over {oe_n, out, pull up, pull down, level}
    function automatic logic [9:0] pin_exp(input logic [3:0] c, input logic d, input logic a, input logic e);
        logic v;
        v = (c == gpcfg_pkg::M_ALT_PP || c == gpcfg_pkg::M_ALT_OD) ? a : d;
        if (c == gpcfg_pkg::M_ANALOG) return {5'h17, 5'h11};
        if (c == gpcfg_pkg::M_IN_FLOAT || c == UNLISTED) return {5'h17, 4'h8, e};
        if (c == gpcfg_pkg::M_IN_PULL) return {5'h17, 2'h2, d, ~d, d};
        if ((c == gpcfg_pkg::M_OUT_OD || c == gpcfg_pkg::M_ALT_OD) && v) return {5'h16, 5'h10};
        return {5'h1f, 1'h0, v, 2'h0, v};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1 d = rdata_out;
        @(posedge clk_in);
    endtask
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m, input string s);
        comparisons++;
        if ((g & m) !== (e & m)) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, s, g & m, e & m);
        end
    endtask
    task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] g;
        rd(a, g);
        chk_val(g, e, 32'hffff_ffff, "register");
    endtask
    task automatic chk_pin(input int i, input logic [9:0] me);
        logic [4:0] g;
        g = {pad_oe_n_out[i], pad_out[i], pull_up_out[i], pull_down_out[i], level_out[i]};
        chk_val({27'h0, g}, {27'h0, me[4:0]}, {27'h0, me[9:5]}, "pin");
    endtask
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(100000);
        fails++;
        conclude();
    end

    initial begin
        static logic [3:0] codes [8] = '{gpcfg_pkg::M_ANALOG, gpcfg_pkg::M_OUT_PP, gpcfg_pkg::M_IN_FLOAT,
            gpcfg_pkg::M_OUT_OD, gpcfg_pkg::M_IN_PULL, gpcfg_pkg::M_ALT_PP, gpcfg_pkg::M_ALT_OD, UNLISTED};
        logic [15:0] m;
        logic [7:0] od;
        logic [31:0] g;
        logic s;
        int idx;
        void'($urandom(32'h3737));
        cyc(6);
        chk_pin(gpcfg_pkg::BOOT_SEL_PIN, {5'h14, 5'h14});
        cyc(2);
        srst_in <= 1'h0;
        por_in <= 1'h0;
        boot_select_in_n <= 1'h1;
        forced_debug_in <= 1'h1;
        cyc(1);
        for (int p = 0; p < 3; p++) begin
            chk_reg(base(p), 32'h0000_4444);
            chk_reg(base(p) + gpcfg_pkg::MODE_HIGH_OFS, 32'h0000_4444);
        end
        chk_reg(gpcfg_pkg::DEBUG_CTRL_ADDR, 32'h0000_0000);
        wr(gpcfg_pkg::DEBUG_STATE_ADDR, 32'hffff_ffff);
        chk_reg(gpcfg_pkg::DEBUG_STATE_ADDR, 32'h0000_000a);
        chk_reg(32'h4000_bc40, 32'h0000_0000);
        wr(base(0), 32'hffff_1111);
        chk_reg(base(0), 32'h0000_1111);
        $display("test reset and status done");
        for (int p = 0; p < 3; p++) begin
            for (int n = 0; n < 4; n++) begin
                for (int k = 0; k < 8; k++) begin
                    idx = p * 8 + n;
                    od = 8'($urandom);
                    alt_data_in <= 24'($urandom);
                    timer_ch_in <= 4'($urandom);
                    ext_level <= 24'($urandom);
                    // outside driver only where the pin listens without pulls
                    ext_en <= (codes[k] == gpcfg_pkg::M_IN_FLOAT || codes[k] == UNLISTED) ? 24'h00_0001 << idx
                        : 24'h00_0000;
                    m = 16'h4444;
                    m[n * 4 +: 4] = codes[k];
                    wr(base(p) + gpcfg_pkg::OUT_DATA_OFS, {24'h00_0000, od});
                    wr(base(p), {16'h0000, m});
                    cyc(3);
                    chk_pin(idx, pin_exp(codes[k], od[n], (p == 0) ? timer_ch_in[pa_ch[n]] : alt_data_in[idx],
                        ext_level[idx]));
                    chk_reg(base(p), {16'h0000, m});
                    rd(base(p) + gpcfg_pkg::IN_LEVEL_OFS, g);
                    if (codes[k] == gpcfg_pkg::M_ANALOG) chk_val(g, 32'h1 << n, 32'h1 << n, "input");
                end
            end
        end
        $display("test mode codes done");
        wr(base(0) + gpcfg_pkg::MODE_HIGH_OFS, 32'h0000_4414);
        srst_in <= 1'h1;
        cyc(3);
        chk_pin(gpcfg_pkg::BOOT_SEL_PIN, {5'h14, 5'h14});
        srst_in <= 1'h0;
        cyc(1);
        chk_reg(gpcfg_pkg::DEBUG_STATE_ADDR, 32'h0000_000a);
        srst_in <= 1'h1;
        external_reset_in_n <= 1'h0;
        cyc(2);
        srst_in <= 1'h0;
        external_reset_in_n <= 1'h1;
        cyc(1);
        chk_reg(gpcfg_pkg::DEBUG_STATE_ADDR, 32'h0000_0002);
        for (int v = 0; v < 2; v++) begin
            reg_enable_in <= 1'(v);
            cyc(3);
            chk_pin(gpcfg_pkg::REG_EN_PIN, {1'h1, ~1'(v), 3'h0, 1'(v), 4'h0});
        end
        $display("test reset overrides done");
        jtag_data_out_in <= 1'($urandom);
        jtag_on_in <= 1'h1;
        cyc(3);
        chk_pin(gpcfg_pkg::JTAG_RST_PIN, {5'h14, 5'h14});
        chk_pin(gpcfg_pkg::JTAG_TDI_PIN, {5'h14, 5'h14});
        chk_pin(gpcfg_pkg::JTAG_TDO_PIN, {5'h18, 1'h0, jtag_data_out_in, 3'h0});
        wr(gpcfg_pkg::DEBUG_CTRL_ADDR, 32'h0000_0001);
        cyc(2);
        chk_val({31'h0, debugger_disable_out}, 32'h1, 32'h1, "disable");
        chk_pin(gpcfg_pkg::JTAG_TDO_PIN, {5'h10, 5'h10});
        wr(gpcfg_pkg::DEBUG_CTRL_ADDR, 32'h0000_0000);
        jtag_on_in <= 1'h0;
        sw_on_in <= 1'h1;
        for (int v = 0; v < 2; v++) begin
            s = 1'($urandom);
            sw_drive_in <= 1'(v);
            sw_data_in <= s;
            ext_en <= {3'h0, ~1'(v), 20'h0_0000};
            ext_level <= {24{s}};
            cyc(4);
            chk_pin(gpcfg_pkg::SW_DATA_PIN, {1'h1, 1'(v), 3'h7, ~1'(v), s & 1'(v), 2'h0, s});
        end
        chk_reg(gpcfg_pkg::DEBUG_STATE_ADDR, 32'h0000_0003);
        sw_on_in <= 1'h0;
        $display("test debug overrides done");
        wr(gpcfg_pkg::DEBUG_CTRL_ADDR, 32'h0000_0002);
        // timer levels differ from the plain peripheral data, so a missed remap shows
        timer_ch_in <= ~alt_data_in[12:9];
        wr(base(1), 32'h0000_9994);
        wr(base(1) + gpcfg_pkg::MODE_HIGH_OFS, 32'h0000_4449);
        cyc(3);
        chk_val({31'h0, timer_remap_out}, 32'h1, 32'h1, "remap");
        for (int c = 0; c < 4; c++) begin
            chk_pin(gpcfg_pkg::TIMER_REMAP_BASE + c, pin_exp(gpcfg_pkg::M_ALT_PP, 1'h0, timer_ch_in[c], 1'h0));
        end
        $display("test timer remap done");
        conclude();
    end
endmodule
`default_nettype wire
